// [hdl/instr_fifo.sv]
`timescale 1ns/1ps
// small flip-flop fifo with valid and ready on both sides
module instr_fifo #(
    parameter int unsigned width = 32,
    parameter int unsigned depth = 8
) (
    input wire logic clock_in, // system clock
    input wire logic rst_in, // async reset, high
    input wire logic flush_in, // drop all contents
    input wire logic [width-1:0] wr_data_in, // write word
    input wire logic wr_valid_in, // write request
    output logic wr_ready_out, // room available
    output logic [width-1:0] rd_data_out, // head word
    output logic rd_valid_out, // head valid
    input wire logic rd_ready_in // consumer takes head
);
    localparam int unsigned aw = $clog2(depth);

    typedef struct packed {
        logic [aw:0] wr_ptr;
        logic [aw:0] rd_ptr;
    } fifo_state_t;

    fifo_state_t state;
    fifo_state_t next_state;
    logic [width-1:0] mem [depth];
    logic full;
    logic empty;
    logic push;
    logic pop;

    // full and empty from pointer wrap bits
    assign empty = (state.wr_ptr == state.rd_ptr);
    assign full = (state.wr_ptr[aw-1:0] == state.rd_ptr[aw-1:0]) &&
                  (state.wr_ptr[aw] != state.rd_ptr[aw]);
    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out = mem[state.rd_ptr[aw-1:0]];
    assign push = wr_valid_in && !full;
    assign pop = rd_ready_in && !empty;

    // pointer update
    always_comb begin
        next_state = state;
        if (flush_in) begin
            next_state.rd_ptr = state.wr_ptr;
        end else begin
            if (push) next_state.wr_ptr = state.wr_ptr + 1'b1;
            if (pop) next_state.rd_ptr = state.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // storage written by index
    always_ff @(posedge clock_in) begin
        if (push && !flush_in) begin
            mem[state.wr_ptr[aw-1:0]] <= wr_data_in;
        end
    end
endmodule : instr_fifo

// [hdl/serial_prog_front.sv]
`timescale 1ns/1ps
// serial programming port front end: link shifter, enable handshake, instruction fifo

// What this block does
// - sample data input on each rising serial clock edge while programming.
// - shift each output bit on the falling serial clock edge.
// - programming works only with a valid cpu clock from selected source.
// - internal oscillator needs no clock on the crystal input pin.
// - chip erase sets every program and eeprom location to 0xff.
// - port active only with reset pin low; enable instruction comes first.
// - echo 0x53 on data output during third byte of enable instruction.
module serial_prog_front (
    input wire logic clock_in, // cpu clock, 200 MHz
    input wire logic rst_in, // async reset, high
    input wire logic internal_osc_in, // clock source fuses pick internal oscillator
    input wire logic crystal_clock_ok_in, // crystal input pin sees a clock
    input wire logic reset_pin_in, // device reset pin, active high idle
    input wire logic serial_prog_clock_in, // serial clock from programmer
    input wire logic serial_prog_data_in, // serial data from programmer
    output logic serial_prog_data_out, // serial data to programmer
    output logic serial_prog_data_oe_out, // drive enable for data output
    output logic prog_enabled_out, // enable instruction accepted
    output logic chip_erase_req_out, // pulse: erase all to erased_value
    output serial_prog_pkg::instr_t instr_out, // instruction at fifo head
    output logic instr_valid_out, // fifo head valid
    input wire logic instr_ready_in, // consumer takes instruction
    input wire logic [7:0] reply_byte_in, // byte returned as fourth byte
    output logic instr_dropped_out // pulse: fifo full, instruction lost
);
    import serial_prog_pkg::*;

    typedef enum logic [1:0] {idle, shifting, held} link_mode_t;

    typedef struct packed {
        link_pins_t sync1;
        link_pins_t sync2;
        logic sck_prev;
        link_mode_t mode;
        logic [2:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic [7:0] shift_in;
        logic [7:0] shift_out;
        logic [23:0] head;
        logic enabled;
        logic data_out;
        logic erase_pulse;
        logic drop_pulse;
        instr_t pending;
        logic pending_valid;
    } front_state_t;

    front_state_t state;
    front_state_t next_state;
    logic clock_good;
    logic port_active;
    logic rise;
    logic fall;
    logic [7:0] assembled;
    logic fifo_ready;

    // valid cpu clock: internal oscillator needs no crystal clock
    assign clock_good = internal_osc_in || crystal_clock_ok_in;
    // port listens only while the reset pin is held low
    assign port_active = !state.sync2.reset_pin && clock_good;
    // edges seen only on the second synchroniser stage
    assign rise = state.sync2.sck && !state.sck_prev;
    assign fall = !state.sync2.sck && state.sck_prev;
    assign assembled = {state.shift_in[6:0], state.sync2.data};

    // next state of link, counters and handshake
    always_comb begin
        next_state = state;
        next_state.sync1 = '{sck: serial_prog_clock_in, data: serial_prog_data_in,
                             reset_pin: reset_pin_in};
        next_state.sync2 = state.sync1;
        next_state.sck_prev = state.sync2.sck;
        next_state.erase_pulse = 1'b0;
        next_state.drop_pulse = 1'b0;
        if (state.pending_valid && fifo_ready) next_state.pending_valid = 1'b0;
        if (!port_active) begin
            // reset pin high drops sync and the enable state
            next_state.mode = idle;
            next_state.bit_cnt = bit_count_reset;
            next_state.byte_cnt = byte_count_reset;
            next_state.enabled = 1'b0;
            next_state.shift_out = '0;
            next_state.data_out = 1'b0;
        end else begin
            unique case (state.mode)
                idle: begin
                    next_state.mode = shifting;
                end
                shifting, held: begin
                    if (rise) begin
                        // capture one bit, msb first
                        next_state.shift_in = assembled;
                        next_state.bit_cnt = state.bit_cnt + 3'h1;
                        next_state.mode = held;
                        if (state.bit_cnt == 3'(bits_per_byte - 1)) begin
                            next_state.byte_cnt = state.byte_cnt + 2'h1;
                            unique case (state.byte_cnt)
                                2'h0: next_state.head[23:16] = assembled;
                                2'h1: begin
                                    next_state.head[15:8] = assembled;
                                    // echo second byte of enable while third shifts
                                    next_state.shift_out = (state.head[23:16] == enable_byte1)
                                        ? assembled : 8'h00;
                                end
                                2'h2: begin
                                    next_state.head[7:0] = assembled;
                                    next_state.shift_out = reply_byte_in;
                                end
                                2'h3: begin
                                    // whole instruction received
                                    next_state.shift_out = '0;
                                    if (state.head[23:16] == enable_byte1 &&
                                        state.head[15:8] == enable_byte2) begin
                                        next_state.enabled = 1'b1;
                                    end else if (state.enabled) begin
                                        if (state.head[23:16] == enable_byte1 &&
                                            state.head[15:8] == erase_byte2) begin
                                            next_state.erase_pulse = 1'b1;
                                        end
                                        if (state.pending_valid && !fifo_ready) begin
                                            next_state.drop_pulse = 1'b1;
                                        end else begin
                                            next_state.pending = {state.head, assembled};
                                            next_state.pending_valid = 1'b1;
                                        end
                                    end
                                end
                            endcase
                        end
                    end else if (fall) begin
                        // launch next outgoing bit, msb first
                        next_state.data_out = state.shift_out[7];
                        next_state.shift_out = {state.shift_out[6:0], 1'b0};
                        next_state.mode = shifting;
                    end
                end
                default: next_state.mode = idle;
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // instructions wait here until the memory controller takes them
    instr_fifo #(
        .width(fifo_width),
        .depth(fifo_depth)
    ) u_fifo (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .flush_in(1'b0),
        .wr_data_in(state.pending),
        .wr_valid_in(state.pending_valid),
        .wr_ready_out(fifo_ready),
        .rd_data_out(instr_out),
        .rd_valid_out(instr_valid_out),
        .rd_ready_in(instr_ready_in)
    );

    assign serial_prog_data_out = state.data_out;
    assign serial_prog_data_oe_out = port_active;
    assign prog_enabled_out = state.enabled;
    assign chip_erase_req_out = state.erase_pulse;
    assign instr_dropped_out = state.drop_pulse;
endmodule : serial_prog_front

// [shared/serial_prog_pkg.sv]
// shared constants and types for the serial programming front end
package serial_prog_pkg;
    localparam int unsigned clock_mhz = 200;
    localparam int unsigned sync_stages = 2;
    localparam int unsigned bits_per_byte = 8;
    localparam int unsigned bytes_per_instr = 4;
    localparam int unsigned fifo_width = 32;
    localparam int unsigned fifo_depth = 8;
    // least serial clock phase, in cpu clocks, at or above 12 MHz
    localparam int unsigned min_phase_cycles = 3;
    localparam int unsigned fast_clock_mhz = 12;
    localparam int unsigned phase_cycles = (clock_mhz >= fast_clock_mhz) ? min_phase_cycles : 2;
    localparam logic [7:0] enable_byte1 = 8'hac;
    localparam logic [7:0] enable_byte2 = 8'h53;
    localparam logic [7:0] erase_byte2 = 8'h80;
    localparam logic [7:0] erased_value = 8'hff;
    localparam logic [2:0] bit_count_reset = 3'h0;
    localparam logic [1:0] byte_count_reset = 2'h0;

    // one whole four-byte instruction as handed downstream
    typedef struct packed {
        logic [7:0] byte1;
        logic [7:0] byte2;
        logic [7:0] byte3;
        logic [7:0] byte4;
    } instr_t;

    // link pins after synchronisation
    typedef struct packed {
        logic sck;
        logic data;
        logic reset_pin;
    } link_pins_t;
endpackage : serial_prog_pkg

// [test/prog_link.sv]
// behavioural programmer on the far side of the serial link
`timescale 1ns/1ps
module prog_link (
    input wire logic clock_in, // cpu clock, times the reset pulse
    input wire logic sdo_in, // data from device
    output logic sck_out, // serial clock
    output logic sdi_out, // data to device
    output logic rst_pin_out // device reset pin
);
    // power up with reset pin and clock low
    initial begin
        sck_out = 1'b0;
        sdi_out = 1'b0;
        rst_pin_out = 1'b0;
    end
    // one bit: data set while low, answer taken at the rising edge
    task automatic bit_io(input logic b, output logic r);
        sdi_out = b;
        #61 sck_out = 1'b1;
        r = sdo_in;
        #64 sck_out = 1'b0;
    endtask : bit_io
    // whole four-byte instruction, msb first, clock still afterwards
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        for (int i = 31; i >= 0; i--) bit_io(tx[i], rx[i]);
        sdi_out = ~sdi_out; // idle line shows the inverse
    endtask : xfer
    // resync: clock low, reset pin high five cycles, settle time shortened
    task automatic pulse_reset();
        sck_out = 1'b0;
        repeat (5) @(negedge clock_in) rst_pin_out = 1'b1;
        @(negedge clock_in) rst_pin_out = 1'b0;
        #20000;
    endtask : pulse_reset
endmodule : prog_link

// [test/serial_prog_front_chk.sv]
// port assertions for the serial programming front end
`timescale 1ns/1ps
module serial_prog_front_chk (
    input wire logic clock_in, // cpu clock
    input wire logic rst_in, // async reset
    input wire logic internal_osc_in, // internal oscillator picked
    input wire logic crystal_clock_ok_in, // crystal clock present
    input wire logic reset_pin_in, // device reset pin
    input wire logic serial_prog_clock_in, // serial clock
    input wire logic serial_prog_data_out, // serial data out
    input wire logic serial_prog_data_oe_out, // data drive enable
    input wire logic prog_enabled_out, // enable accepted
    input wire logic chip_erase_req_out, // erase pulse
    input wire serial_prog_pkg::instr_t instr_out, // fifo head
    input wire logic instr_valid_out, // head valid
    input wire logic instr_ready_in, // head taken
    input wire logic instr_dropped_out // drop pulse
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // drive enable against reset pin and clock source
    AST_OE_RESET_PIN: assert property (reset_pin_in [*4] |-> !serial_prog_data_oe_out)
        else $error("data drive on while reset pin high");
    AST_OE_NO_CLOCK: assert property (!internal_osc_in && !crystal_clock_ok_in |->
        !serial_prog_data_oe_out) else $error("data drive on without clock");
    AST_OE_INT_OSC: assert property ((!reset_pin_in) [*5] ##0 internal_osc_in |->
        serial_prog_data_oe_out) else $error("data drive off on internal oscillator");
    // output bit moves only after a falling serial clock
    AST_DOUT_ON_FALL: assert property ($changed(serial_prog_data_out) && !reset_pin_in |->
        !$past(serial_prog_clock_in, 3)) else $error("data out moved outside low phase");
    AST_ENABLE_CLEAR: assert property (reset_pin_in [*4] |-> !prog_enabled_out)
        else $error("enabled kept with reset pin high");
    AST_ENABLE_ON_RISE: assert property ($rose(prog_enabled_out) |->
        $past(serial_prog_clock_in, 2)) else $error("enable not after rising clock");
    AST_WRITE_ON_RISE: assert property ($rose(instr_valid_out) |->
        $past(serial_prog_clock_in, 2)) else $error("fifo write not after rising clock");
    AST_ERASE_PULSE: assert property (chip_erase_req_out |->
        prog_enabled_out ##1 !chip_erase_req_out) else $error("bad erase pulse");
    AST_DROP_PULSE: assert property (instr_dropped_out |->
        instr_valid_out ##1 !instr_dropped_out) else $error("bad drop pulse");
    AST_HEAD_HOLDS: assert property (instr_valid_out && !instr_ready_in |=>
        instr_valid_out && $stable(instr_out)) else $error("fifo head moved untaken");
endmodule : serial_prog_front_chk

bind serial_prog_front serial_prog_front_chk serial_prog_front_chk_i (.clock_in, .rst_in,
    .internal_osc_in, .crystal_clock_ok_in, .reset_pin_in, .serial_prog_clock_in,
    .serial_prog_data_out, .serial_prog_data_oe_out, .prog_enabled_out, .chip_erase_req_out,
    .instr_out, .instr_valid_out, .instr_ready_in, .instr_dropped_out);

// [test/test_serial_prog_front.sv]
// self-checking bench for the serial programming front end
`timescale 1ns/1ps
module test_serial_prog_front;
    import serial_prog_pkg::*;
    logic clock_in = 1'b0, rst_in = 1'b1, osc = 1'b1, xtal = 1'b0, ready = 1'b0, stall = 1'b0;
    logic rpin, sck, sdi, sdo, oe, en, erase, valid, drop;
    logic [7:0] reply = 8'h00;
    instr_t instr;
    instr_t exp_q[$];
    int n_fail = 0, cmp_count = 0, cyc = 0, n_erase = 0, n_drop = 0;
    serial_prog_front serial_prog_front_i (.clock_in, .rst_in, .internal_osc_in(osc),
        .crystal_clock_ok_in(xtal), .reset_pin_in(rpin), .serial_prog_clock_in(sck),
        .serial_prog_data_in(sdi), .serial_prog_data_out(sdo), .serial_prog_data_oe_out(oe),
        .prog_enabled_out(en), .chip_erase_req_out(erase), .instr_out(instr),
        .instr_valid_out(valid), .instr_ready_in(ready), .reply_byte_in(reply),
        .instr_dropped_out(drop));
    // undriven data line shows the inverse of the last bit
    prog_link prog_link_i (.clock_in, .sdo_in(oe ? sdo : ~sdo), .sck_out(sck), .sdi_out(sdi),
        .rst_pin_out(rpin));
    initial begin
        forever #2.5 clock_in = ~clock_in;
    end
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word
    task automatic check_bit(input string what, input logic exp, input logic got);
        check_word(what, {31'h0, exp}, {31'h0, got});
    endtask : check_bit
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // consumer with random stalls
    always @(negedge clock_in) if (!rst_in) ready <= !stall && ($urandom % 3 != 0);
    // watcher: pulses counted, each taken instruction against the oldest note
    always @(posedge clock_in) begin
        cyc++;
        if (cyc > 40000) begin
            n_fail++;
            report_and_stop();
        end
        if (erase === 1'b1) n_erase++;
        if (drop === 1'b1) n_drop++;
        if (valid === 1'b1 && ready) begin
            if (exp_q.size() == 0) check_bit("surplus instr", 1'b0, valid);
            else check_word("instr", exp_q.pop_front(), instr);
        end
    end
    // one plain instruction with random fields, noted unless it will be ignored or dropped
    task automatic send_rand(input bit note);
        logic [31:0] w;
        logic [31:0] rx;
        w = $urandom;
        if (w[31:24] == enable_byte1) w[31:24] = 8'h20;
        @(negedge clock_in) reply = 8'($urandom);
        if (note) exp_q.push_back(w);
        prog_link_i.xfer(w, rx);
        check_word("reply", {24'h0, reply}, {24'h0, rx[7:0]});
    endtask : send_rand
    task automatic enable_seq();
        logic [31:0] rx;
        prog_link_i.xfer({enable_byte1, enable_byte2, 16'h0000}, rx);
        check_word("echo", {24'h0, enable_byte2}, {24'h0, rx[15:8]});
        repeat (12) @(negedge clock_in);
        check_bit("enabled", 1'b1, en);
    endtask : enable_seq
    task automatic drain();
        for (int k = 0; k < 3000 && exp_q.size() > 0; k++) @(negedge clock_in);
        check_word("left", 32'h0, 32'(exp_q.size()));
    endtask : drain
    initial begin
        logic [31:0] rx;
        logic b;
        void'($urandom(32'h63e9e209));
        repeat (5) @(negedge clock_in);
        rst_in = 1'b0;
        repeat (8) @(negedge clock_in);
        check_bit("oe internal osc", 1'b1, oe);
        @(negedge clock_in) osc = 1'b0;
        #1 check_bit("oe no clock", 1'b0, oe);
        @(negedge clock_in) xtal = 1'b1;
        #1 check_bit("oe crystal", 1'b1, oe);
        send_rand(1'b0);
        check_bit("not enabled", 1'b0, en);
        enable_seq();
        for (int i = 0; i < 6; i++) send_rand(1'b1);
        exp_q.push_back({enable_byte1, erase_byte2, 16'h0000});
        prog_link_i.xfer({enable_byte1, erase_byte2, 16'h0000}, rx);
        drain();
        check_word("erase pulses", 32'h1, 32'(n_erase));
        @(negedge clock_in) stall = 1'b1;
        for (int i = 0; i < 10; i++) send_rand(i < 9);
        repeat (12) @(negedge clock_in);
        check_word("drops", 32'h1, 32'(n_drop));
        stall = 1'b0;
        drain();
        for (int i = 0; i < 5; i++) prog_link_i.bit_io(1'b1, b);
        prog_link_i.pulse_reset();
        check_bit("enable cleared", 1'b0, en);
        enable_seq();
        report_and_stop();
    end
endmodule : test_serial_prog_front
